// ### src/osq_pkg.sv
// osq_pkg: constants, command codes and carrier types of the optical measurement sequencer.
// assumes a 200 MHz core clock; shared by the sequencer and its conversion timer.
package osq_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	// shortest integration, 25.6 us; longer ones are this doubled per code step
	localparam int INTEG_BASE_PS = 25_600_000;
	localparam int INTEG_BASE_CYC = (INTEG_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// code 4 gives 410 us, code 7 gives 3.28 ms
	localparam int INTEG_CODE_W = 3;
	localparam int INTEG_CNT_W = 20;
	// one step of the autonomous measurement interval, 31.25 us
	localparam int RATE_TICK_PS = 31_250_000;
	localparam int RATE_TICK_CYC = (RATE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RATE_W = 16;
	localparam int RATE_CNT_W = 29;

	localparam int NUM_CH = 5;
	localparam int NUM_PS = 3;
	localparam int NUM_LED = 3;
	localparam int CUR_W = 4;
	localparam int RES_W = 16;
	localparam logic [2:0] CH_VIS = 3'h3;
	localparam logic [2:0] CH_IR = 3'h4;
	localparam logic [4:0] PS_MASK = 5'h07;
	localparam logic [4:0] ALS_MASK = 5'h18;
	localparam logic [RES_W-1:0] RESULT_SAT = 16'hffff;

	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_PS_FORCE = 4'h1;
	localparam logic [3:0] CMD_ALS_FORCE = 4'h2;
	localparam logic [3:0] CMD_ALL_FORCE = 4'h3;
	localparam logic [3:0] CMD_AUTO_GO = 4'h4;
	localparam logic [3:0] CMD_AUTO_STOP = 4'h5;

	typedef struct packed {
		logic [INTEG_CODE_W-1:0] time_code;
		logic high_range;
	} osq_adc_cfg_t;

	typedef logic [NUM_CH-1:0][RES_W-1:0] osq_results_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_DONE = 4'b1000
	} osq_state_t;

	typedef enum logic [1:0] {
		CV_IDLE = 2'b01,
		CV_INTEG = 2'b10
	} osq_conv_state_t;
endpackage

// ### src/osq_conv.sv
// osq_conv: one ADC conversion, timed integration then capture of the sample.
// assumes the analog front end delivers sample and saturation on the core clock.
`timescale 1ns/1ps
`default_nettype none
module osq_conv #(
	parameter int BASE_CYC = osq_pkg::INTEG_BASE_CYC
) (
	// clock and control
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	input wire osq_pkg::osq_adc_cfg_t cfg,
	// analog front end
	input wire logic [osq_pkg::RES_W-1:0] adc_sample,
	input wire logic adc_sat,
	// conversion outcome
	output logic integrating,
	output logic done,
	output logic [osq_pkg::RES_W-1:0] result,
	output logic overflow
);
	localparam int CW = osq_pkg::INTEG_CNT_W;
	osq_pkg::osq_conv_state_t state, next_state;
	logic [CW-1:0] cnt, next_cnt, len, next_len;
	logic next_done, next_overflow;
	logic [osq_pkg::RES_W-1:0] next_result;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_len = len;
		next_done = 1'b0;
		next_result = result;
		next_overflow = overflow;
		case (state)
			osq_pkg::CV_IDLE: begin
				if (start) begin
					next_state = osq_pkg::CV_INTEG;
					next_cnt = '0;
					next_len = CW'(BASE_CYC) << cfg.time_code;
				end
			end
			osq_pkg::CV_INTEG: begin
				if (cnt == len - CW'(1)) begin
					next_state = osq_pkg::CV_IDLE;
					next_done = 1'b1;
					// saturation forces all ones; a clean sample is taken as is
					next_result = adc_sat ? osq_pkg::RESULT_SAT : adc_sample;
					next_overflow = adc_sat;
				end else begin
					next_cnt = cnt + CW'(1);
				end
			end
			default: next_state = osq_pkg::CV_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= osq_pkg::CV_IDLE;
			cnt <= '0;
			len <= '0;
			done <= 1'b0;
			result <= '0;
			overflow <= 1'b0;
			integrating <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			cnt <= next_cnt;
			len <= next_len;
			done <= next_done;
			result <= next_result;
			overflow <= next_overflow;
			integrating <= next_state == osq_pkg::CV_INTEG;
		end
	end

	property p_sat_result;
		@(posedge clock) disable iff (!rst_n || !clk_en)
		$rose(done) |-> (overflow == $past(adc_sat))
			&& (result == ($past(adc_sat) ? osq_pkg::RESULT_SAT : $past(adc_sample)));
	endproperty
	a_sat_result: assert property (p_sat_result)
		else $error("conversion result does not follow saturation");
endmodule
`default_nettype wire

// ### src/osq_sequencer.sv
// osq_sequencer: measurement sequencing of the optical proximity and ambient sensor.
// assumes host commands and settings arrive on the core clock from the register front end.
`timescale 1ns/1ps
`default_nettype none
module osq_sequencer #(
	parameter int INTEG_CYC = osq_pkg::INTEG_BASE_CYC,
	parameter int RATE_CYC = osq_pkg::RATE_TICK_CYC
) (
	// clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	// host commands
	input wire logic CMD_VALID,
	input wire logic [3:0] CMD_CODE,
	output logic CMD_READY,
	// configuration
	input wire logic [osq_pkg::NUM_CH-1:0] CHAN_EN,
	input wire logic [osq_pkg::NUM_PS-1:0][osq_pkg::NUM_LED-1:0] LED_SEL,
	input wire logic [osq_pkg::NUM_LED-1:0][osq_pkg::CUR_W-1:0] LED_CURRENT_SET,
	input wire osq_pkg::osq_adc_cfg_t PS_CFG,
	input wire osq_pkg::osq_adc_cfg_t VIS_CFG,
	input wire osq_pkg::osq_adc_cfg_t IR_CFG,
	input wire logic [osq_pkg::RATE_W-1:0] MEAS_RATE,
	input wire logic IRQ_ENABLE,
	input wire logic IRQ_ACK,
	// analog front end
	input wire logic [osq_pkg::RES_W-1:0] ADC_SAMPLE,
	input wire logic ADC_SAT,
	output logic [osq_pkg::NUM_LED-1:0] LED_ON,
	output logic [osq_pkg::NUM_LED-1:0][osq_pkg::CUR_W-1:0] LED_CURRENT,
	output logic ADC_HIGH_RANGE,
	output logic [2:0] ADC_CHAN,
	output logic ADC_INTEGRATE,
	// results and status
	output osq_pkg::osq_results_t RESULTS,
	output logic RESP_OVF,
	output logic AUTO_ACTIVE,
	output logic BUSY,
	// interrupt pin, open drain
	output logic INT_O,
	output logic INT_OE
);
	logic rst_meta, rst_n;
	osq_pkg::osq_state_t state, next_state;
	logic [osq_pkg::NUM_CH-1:0] pend, next_pend;
	logic [2:0] idx, next_idx, sel;
	logic [osq_pkg::RATE_CNT_W-1:0] rate_cnt, next_rate_cnt, rate_limit;
	logic next_auto, next_ovf, next_int, next_range, rate_due;
	logic cmd_take, nop_take, conv_start, ovf_set, int_set;
	logic [osq_pkg::NUM_LED-1:0] next_led, led_pick;
	logic [osq_pkg::NUM_LED-1:0][osq_pkg::CUR_W-1:0] next_cur;
	logic [2:0] next_chan;
	osq_pkg::osq_results_t next_results;
	osq_pkg::osq_adc_cfg_t cfg_sel;
	logic conv_done, conv_ovf, conv_integ;
	logic [osq_pkg::RES_W-1:0] conv_result;

	// reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	function automatic logic [2:0] first_set(input logic [osq_pkg::NUM_CH-1:0] m);
		first_set = 3'h0;
		for (int i = osq_pkg::NUM_CH - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction

	always_comb begin
		next_state = state;
		next_pend = pend;
		next_idx = idx;
		next_auto = AUTO_ACTIVE;
		next_rate_cnt = rate_cnt;
		next_led = LED_ON;
		next_cur = LED_CURRENT;
		next_range = ADC_HIGH_RANGE;
		next_chan = ADC_CHAN;
		next_results = RESULTS;
		conv_start = 1'b0;
		int_set = 1'b0;
		cmd_take = CMD_VALID && CMD_READY;
		nop_take = cmd_take && CMD_CODE == osq_pkg::CMD_NOP;
		sel = first_set(pend);
		led_pick = LED_SEL[sel[1:0]];
		// visible and infrared keep separate settings
		cfg_sel = (sel < 3'(osq_pkg::NUM_PS)) ? PS_CFG
			: (sel == osq_pkg::CH_VIS) ? VIS_CFG : IR_CFG;
		rate_limit = osq_pkg::RATE_CNT_W'(MEAS_RATE) * osq_pkg::RATE_CNT_W'(RATE_CYC);
		rate_due = AUTO_ACTIVE && rate_cnt >= rate_limit;
		if (AUTO_ACTIVE && !rate_due) begin
			next_rate_cnt = rate_cnt + osq_pkg::RATE_CNT_W'(1);
		end
		ovf_set = state == osq_pkg::ST_WAIT && conv_done && conv_ovf;
		case (state)
			osq_pkg::ST_IDLE: begin
				// currents only move between sets, never under a lit LED
				next_cur = LED_CURRENT_SET;
				if (cmd_take) begin
					case (CMD_CODE)
						osq_pkg::CMD_PS_FORCE: begin
							next_pend = CHAN_EN & osq_pkg::PS_MASK;
							next_state = osq_pkg::ST_START;
						end
						osq_pkg::CMD_ALS_FORCE: begin
							next_pend = CHAN_EN & osq_pkg::ALS_MASK;
							next_state = osq_pkg::ST_START;
						end
						osq_pkg::CMD_ALL_FORCE: begin
							next_pend = CHAN_EN;
							next_state = osq_pkg::ST_START;
						end
						osq_pkg::CMD_AUTO_GO: begin
							next_auto = 1'b1;
							next_rate_cnt = '0;
						end
						osq_pkg::CMD_AUTO_STOP: next_auto = 1'b0;
						default: next_state = osq_pkg::ST_IDLE;
					endcase
				end else if (rate_due) begin
					// a due run waits while busy rather than being dropped
					next_pend = CHAN_EN;
					next_state = osq_pkg::ST_START;
					next_rate_cnt = '0;
				end
			end
			osq_pkg::ST_START: begin
				if (pend == '0) begin
					next_state = osq_pkg::ST_DONE;
				end else begin
					conv_start = 1'b1;
					next_idx = sel;
					next_pend = pend & ~(osq_pkg::NUM_CH'(1) << sel);
					next_led = (sel < 3'(osq_pkg::NUM_PS)) ? led_pick : '0;
					next_range = cfg_sel.high_range;
					next_chan = sel;
					next_state = osq_pkg::ST_WAIT;
				end
			end
			osq_pkg::ST_WAIT: begin
				if (conv_done) begin
					next_results[idx] = conv_result;
					next_led = '0;
					next_state = osq_pkg::ST_START;
				end
			end
			osq_pkg::ST_DONE: begin
				int_set = IRQ_ENABLE;
				next_state = osq_pkg::ST_IDLE;
			end
			default: next_state = osq_pkg::ST_IDLE;
		endcase
		// a new event in the clearing cycle wins
		next_ovf = (RESP_OVF && !nop_take) || ovf_set;
		next_int = (INT_OE && !IRQ_ACK) || int_set;
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state <= osq_pkg::ST_IDLE;
			pend <= '0;
			idx <= '0;
			rate_cnt <= '0;
			AUTO_ACTIVE <= 1'b0;
			LED_ON <= '0;
			LED_CURRENT <= '0;
			ADC_HIGH_RANGE <= 1'b0;
			ADC_CHAN <= '0;
			RESULTS <= '0;
			RESP_OVF <= 1'b0;
			CMD_READY <= 1'b0;
			BUSY <= 1'b0;
			INT_O <= 1'b0;
			INT_OE <= 1'b0;
		end else if (CLK_EN) begin
			state <= next_state;
			pend <= next_pend;
			idx <= next_idx;
			rate_cnt <= next_rate_cnt;
			AUTO_ACTIVE <= next_auto;
			LED_ON <= next_led;
			LED_CURRENT <= next_cur;
			ADC_HIGH_RANGE <= next_range;
			ADC_CHAN <= next_chan;
			RESULTS <= next_results;
			RESP_OVF <= next_ovf;
			CMD_READY <= next_state == osq_pkg::ST_IDLE;
			BUSY <= next_state != osq_pkg::ST_IDLE;
			INT_O <= 1'b0;
			INT_OE <= next_int;
		end
	end

	osq_conv #(
		.BASE_CYC(INTEG_CYC)
	) u_conv (
		.clock(CLOCK),
		.rst_n(rst_n),
		.clk_en(CLK_EN),
		.start(conv_start),
		.cfg(cfg_sel),
		.adc_sample(ADC_SAMPLE),
		.adc_sat(ADC_SAT),
		.integrating(conv_integ),
		.done(conv_done),
		.result(conv_result),
		.overflow(conv_ovf)
	);
	assign ADC_INTEGRATE = conv_integ;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!rst_n || !CLK_EN);

	property p_force_start;
		cmd_take && CMD_CODE == osq_pkg::CMD_PS_FORCE |=> state == osq_pkg::ST_START && BUSY;
	endproperty
	a_force_start: assert property (p_force_start) else $error("force did not start");
	property p_auto_fire;
		state == osq_pkg::ST_IDLE && rate_due && !cmd_take |=> state == osq_pkg::ST_START
			&& rate_cnt == '0;
	endproperty
	a_auto_fire: assert property (p_auto_fire) else $error("due run not started");
	property p_skip_off;
		state == osq_pkg::ST_START && pend == '0 |=> state == osq_pkg::ST_DONE ##1 !BUSY;
	endproperty
	a_skip_off: assert property (p_skip_off) else $error("set did not finish");
	property p_led_sel;
		conv_start && sel < 3'(osq_pkg::NUM_PS) |=> LED_ON == $past(led_pick) && ADC_INTEGRATE;
	endproperty
	a_led_sel: assert property (p_led_sel) else $error("wrong LED set");
	property p_int_set;
		state == osq_pkg::ST_DONE && IRQ_ENABLE |=> INT_OE && !INT_O;
	endproperty
	a_int_set: assert property (p_int_set) else $error("no interrupt after set");
	property p_cur_hold;
		state != osq_pkg::ST_IDLE |=> $stable(LED_CURRENT);
	endproperty
	a_cur_hold: assert property (p_cur_hold) else $error("current moved mid set");
	property p_ovf_sticky;
		RESP_OVF && !nop_take |=> RESP_OVF;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");
	property p_nop_clear;
		nop_take && !ovf_set |=> !RESP_OVF;
	endproperty
	a_nop_clear: assert property (p_nop_clear) else $error("no-op did not clear");
	property p_cmd_ovf;
		RESP_OVF && state == osq_pkg::ST_IDLE |-> CMD_READY;
	endproperty
	a_cmd_ovf: assert property (p_cmd_ovf) else $error("command refused");
	property p_int_hold;
		INT_OE && !IRQ_ACK |=> INT_OE;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("interrupt dropped");
	property p_result_whole;
		state == osq_pkg::ST_WAIT && conv_done |=> RESULTS[idx] == $past(conv_result);
	endproperty
	a_result_whole: assert property (p_result_whole) else $error("result not stored");

	c_set_int: cover property (state == osq_pkg::ST_DONE ##1 INT_OE);
	c_auto_run: cover property (AUTO_ACTIVE && rate_due ##1 state == osq_pkg::ST_START);
	c_ovf: cover property (ovf_set ##1 RESP_OVF);
	c_nop_clr: cover property (RESP_OVF && nop_take ##1 !RESP_OVF);
endmodule
`default_nettype wire

// ### sim/osq_fe_model.sv
// osq_fe_model: analog front end that answers the sequencer's conversions.
// assumes the bench sets levels and saturation mask between measurement sets.
`timescale 1ns/1ps
`default_nettype none
module osq_fe_model (
	// clock and conversion state
	input wire logic clock,
	input wire logic integrate,
	input wire logic [2:0] chan,
	// light level and saturation per channel
	input wire logic [4:0][15:0] level,
	input wire logic [4:0] over,
	// to the sequencer
	output logic [15:0] sample,
	output logic sat
);
	logic [15:0] churn = 16'h5a5a;
	// outside integration the value churns so stale data is never trusted
	always_ff @(posedge clock) begin
		churn <= ~churn;
	end
	assign sample = integrate ? level[chan] : churn;
	assign sat = integrate ? over[chan] : churn[0];
endmodule
`default_nettype wire

// ### sim/optical_measurement_sequencer_tb.sv
// optical_measurement_sequencer_tb: self-checking bench of the sequencer.
// assumes shortened integration and rate counts; front end from osq_fe_model.
`timescale 1ns/1ps
`default_nettype none
module optical_measurement_sequencer_tb;
	localparam int IC = 4;
	localparam int RC = 8;
	logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, irq_enable = 1'b0, irq_ack = 1'b0;
	logic [3:0] cmd_code = 4'h0;
	logic [4:0] chan_en = 5'h1f, over = 5'h00;
	logic [2:0][2:0] led_sel = 9'h0;
	logic [2:0][3:0] led_current_set = 12'h0;
	osq_pkg::osq_adc_cfg_t ps_cfg = 4'h0, vis_cfg = 4'h0, ir_cfg = 4'h0;
	logic [15:0] meas_rate = 16'h0;
	logic [4:0][15:0] level = 80'h0;
	logic [15:0] adc_sample;
	logic adc_sat, cmd_ready, adc_high_range, adc_integrate, resp_ovf, auto_active, busy, int_o;
	logic int_oe;
	logic [2:0] led_on, adc_chan;
	logic [2:0][3:0] led_current;
	osq_pkg::osq_results_t results;
	int n_fail = 0, num_checks = 0, cyc = 0, icnt = 0, lastch = 0, k;
	int seed = 32'hd7f9bd1e;
	int exp_res[5] = '{0, 0, 0, 0, 0};
	logic exp_ovf = 1'b0;
	logic [4:0] masks[4] = '{5'h00, 5'h07, 5'h18, 5'h1f};
	// channels the running set may convert; conversions counted against it per set
	logic [4:0] run_mask = 5'h00;
	int nconv = 0, conv_base = 0;
	osq_pkg::osq_adc_cfg_t cur_cfg;

	initial forever #2.5 clock = ~clock;

	osq_sequencer #(.INTEG_CYC(IC), .RATE_CYC(RC)) dut (
		.CLOCK(clock), .RST_N(rst_n), .CLK_EN(1'b1),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_READY(cmd_ready),
		.CHAN_EN(chan_en), .LED_SEL(led_sel), .LED_CURRENT_SET(led_current_set),
		.PS_CFG(ps_cfg), .VIS_CFG(vis_cfg), .IR_CFG(ir_cfg), .MEAS_RATE(meas_rate),
		.IRQ_ENABLE(irq_enable), .IRQ_ACK(irq_ack),
		.ADC_SAMPLE(adc_sample), .ADC_SAT(adc_sat), .LED_ON(led_on),
		.LED_CURRENT(led_current), .ADC_HIGH_RANGE(adc_high_range), .ADC_CHAN(adc_chan),
		.ADC_INTEGRATE(adc_integrate), .RESULTS(results), .RESP_OVF(resp_ovf),
		.AUTO_ACTIVE(auto_active), .BUSY(busy), .INT_O(int_o), .INT_OE(int_oe)
	);

	osq_fe_model fe (
		.clock(clock), .integrate(adc_integrate), .chan(adc_chan),
		.level(level), .over(over), .sample(adc_sample), .sat(adc_sat)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic osq_pkg::osq_adc_cfg_t cfg_of(input int ch);
		return (ch < 3) ? ps_cfg : (ch == 3) ? vis_cfg : ir_cfg;
	endfunction

	task automatic cmd(input logic [3:0] code);
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		cmd_valid = 1'b1;
		cmd_code = code;
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask

	task automatic model_set(input logic [4:0] m);
		for (int i = 0; i < 5; i++) begin
			if (m[i]) begin
				exp_res[i] = over[i] ? 16'hffff : level[i];
				exp_ovf = exp_ovf | over[i];
			end
		end
		for (int i = 0; i < 5; i++)
			check("result", results[i], exp_res[i]);
		check("overflow", resp_ovf, exp_ovf);
		check("conversions", nconv - conv_base, $countones(m));
		conv_base = nconv;
	endtask

	task automatic irq_cycle();
		check("irq", int_oe, irq_enable);
		check("irq level", int_o, 1'b0);
		repeat (2) @(negedge clock);
		check("irq held", int_oe, irq_enable);
		irq_ack = 1'b1;
		@(negedge clock);
		irq_ack = 1'b0;
		@(negedge clock);
		check("irq cleared", int_oe, 1'b0);
	endtask

	task automatic force_set(input logic [3:0] code);
		run_mask = chan_en & masks[code];
		cmd(code);
		check("busy", busy, 1'b1);
		while (cmd_ready !== 1'b1) @(negedge clock);
		check("idle", busy, 1'b0);
		model_set(run_mask);
		irq_cycle();
	endtask

	always @(negedge clock) begin
		if (rst_n && adc_integrate === 1'b1) begin
			if (icnt == 0) begin
				check("chan enabled", 32'(run_mask[adc_chan]), 32'h1);
				nconv++;
			end
			icnt++;
			lastch = adc_chan;
			cur_cfg = cfg_of(adc_chan);
			if (adc_chan < 3) begin
				check("led on", led_on, led_sel[adc_chan]);
				check("led current", led_current, led_current_set);
			end else
				check("led off", led_on, 3'h0);
			check("range", adc_high_range, cur_cfg.high_range);
		end else if (icnt != 0) begin
			cur_cfg = cfg_of(lastch);
			check("integration", icnt, IC << cur_cfg.time_code);
			icnt = 0;
		end
	end

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(negedge clock);
		check("ready in reset", cmd_ready, 1'b0);
		check("results in reset", 32'(|results), 32'h0);
		rst_n = 1'b1;
		irq_enable = 1'b1;
		for (k = 0; k < 12; k++) begin
			level = 80'({$random(seed), $random(seed), $random(seed)});
			chan_en = 5'($random(seed));
			led_sel = 9'($random(seed));
			led_current_set = 12'($random(seed));
			// time codes 0..3 keep the shortened run brief
			ps_cfg = 4'($random(seed) & 32'h7);
			vis_cfg = 4'($random(seed) & 32'h7);
			ir_cfg = 4'($random(seed) & 32'h7);
			force_set(4'(1 + k % 3));
		end
		// saturate two channels, then come back in range with the flag still up
		chan_en = 5'h1f;
		over = 5'h09;
		force_set(4'h3);
		over = 5'h00;
		force_set(4'h3);
		cmd(4'h0);
		exp_ovf = 1'b0;
		@(negedge clock);
		check("overflow cleared", resp_ovf, 1'b0);
		irq_enable = 1'b0;
		force_set(4'h2);
		irq_enable = 1'b1;
		meas_rate = 16'h2;
		run_mask = chan_en;
		cmd(4'h4);
		check("auto on", auto_active, 1'b1);
		for (k = 0; k < 500 && int_oe !== 1'b1; k++) @(negedge clock);
		model_set(chan_en);
		irq_cycle();
		cmd(4'h5);
		@(negedge clock);
		check("auto off", auto_active, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
